// File: rtl/ohc_ctrl.sv
// over-current and hall comparator control with apb registers
// Behaviour
// - over-current edge code: off, rise, fall, both
// - over-current dac reference register, reset zero
// - calibration reference picks negative or positive input
// - calibration mode bit: normal or offset calibration
// - five-bit offset trim, resets to center
// - boundary and over-current comparator interrupts
// - over-current event switches motor drive off
// - hall signal compared against hall dac
// - hall comparator and boundary interrupts track position
// - hall dac reference register, reset zero
// - unimplemented bits ignore writes, read zero
// - boundary interrupt on upper or lower exceed
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ohc_params.svh"
module ohc_ctrl
  import ohc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`OHC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ocCmpIn,
  input wire logic hallCmpIn,
  input wire ohc_conv_t conv,
  output ohc_afe_ctrl_t afeCtrl,
  output logic driveOff,
  output logic irq
);

  // comparator is on, with its dac, unless the edge code is off
  function automatic logic edgeOn(input logic [1:0] code);
    edgeOn = (code != `OHC_EDGE_OFF);
  endfunction

  logic [1:0] ocEdge;
  logic [2:0] gainSel;
  logic [`OHC_DAC_W-1:0] ocDac;
  logic calRef;
  logic calMode;
  logic [`OHC_TRIM_W-1:0] trim;
  logic [1:0] hallEdge;
  logic hallIrqEn;
  logic ocIrqEn;
  logic [`OHC_DAC_W-1:0] hallDac;
  logic [`OHC_ST_W-1:0] stat;
  logic [`OHC_ST_W-1:0] mask;
  logic [`OHC_CONV_W-1:0] bndHi;
  logic [`OHC_CONV_W-1:0] bndLo;
  logic [1:0] bndCtl;
  logic [31:0] rdWord;
  logic mapped;
  logic wrEn;
  logic [1:0] edgeSel [2];
  logic cmpIn [2];
  logic cmpEvt [2];
  logic ocEvt;
  logic hallEvt;
  logic bndEvt;
  logic [`OHC_ST_W-1:0] stSet;
  logic [`OHC_ST_W-1:0] stClr;

  // a write takes effect at the edge that completes the access
  assign wrEn = psel & penable & pready & pwrite;

  // one wait state: ready rises once the access phase is seen
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // read data and error captured together with ready
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata <= pwrite ? 32'h0000_0000 : rdWord;
      pslverr <= ~mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // read mux
  // reserved bits zero
  always_comb begin
    rdWord = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      `OHC_GAIN_OFF: begin
        rdWord[`OHC_OCEDGE_LSB +: 2] = ocEdge;
        rdWord[`OHC_GAIN_LSB +: 3] = gainSel;
      end
      `OHC_OCDAC_OFF: begin
        rdWord[`OHC_DAC_W-1:0] = ocDac;
      end
      `OHC_CAL_OFF: begin
        rdWord[`OHC_ARS_BIT] = calRef;
        rdWord[`OHC_CAL_MODE_SEL_BIT] = calMode;
        rdWord[`OHC_TRIM_LSB +: `OHC_TRIM_W] = trim;
      end
      `OHC_HMC_OFF: begin
        rdWord[`OHC_HEDGE_LSB +: 2] = hallEdge;
        rdWord[`OHC_HIEN_BIT] = hallIrqEn;
        rdWord[`OHC_OIEN_BIT] = ocIrqEn;
      end
      `OHC_HDAC_OFF: begin
        rdWord[`OHC_DAC_W-1:0] = hallDac;
      end
      `OHC_STAT_OFF: begin
        rdWord[`OHC_ST_W-1:0] = stat;
      end
      `OHC_MASK_OFF: begin
        rdWord[`OHC_ST_W-1:0] = mask;
      end
      `OHC_BHI_OFF: begin
        rdWord[`OHC_CONV_W-1:0] = bndHi;
      end
      `OHC_BLO_OFF: begin
        rdWord[`OHC_CONV_W-1:0] = bndLo;
      end
      `OHC_BCTL_OFF: begin
        rdWord[1:0] = bndCtl;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // gain and over-current edge register
  // gain resets to ten
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ocEdge <= `OHC_EDGE_OFF;
      gainSel <= `OHC_GAIN_RST;
    end else if (wrEn && paddr == `OHC_GAIN_OFF) begin
      ocEdge <= pwdata[`OHC_OCEDGE_LSB +: 2];
      gainSel <= pwdata[`OHC_GAIN_LSB +: 3];
    end
  end

  // dac reference registers
  // reset zero, full write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ocDac <= `OHC_DAC_RST;
      hallDac <= `OHC_DAC_RST;
    end else if (wrEn) begin
      if (paddr == `OHC_OCDAC_OFF) begin
        ocDac <= pwdata[`OHC_DAC_W-1:0];
      end
      if (paddr == `OHC_HDAC_OFF) begin
        hallDac <= pwdata[`OHC_DAC_W-1:0];
      end
    end
  end

  // offset calibration register
  // calibration fields
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      calRef <= 1'b0;
      calMode <= 1'b0;
      trim <= `OHC_TRIM_RST;
    end else if (wrEn && paddr == `OHC_CAL_OFF) begin
      calRef <= pwdata[`OHC_ARS_BIT];
      calMode <= pwdata[`OHC_CAL_MODE_SEL_BIT];
      trim <= pwdata[`OHC_TRIM_LSB +: `OHC_TRIM_W];
    end
  end

  // hall mode register
  // hall edge, irq enables
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hallEdge <= `OHC_EDGE_OFF;
      hallIrqEn <= 1'b0;
      ocIrqEn <= 1'b0;
    end else if (wrEn && paddr == `OHC_HMC_OFF) begin
      hallEdge <= pwdata[`OHC_HEDGE_LSB +: 2];
      hallIrqEn <= pwdata[`OHC_HIEN_BIT];
      ocIrqEn <= pwdata[`OHC_OIEN_BIT];
    end
  end

  // mask and boundary registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask <= '0;
      bndHi <= '0;
      bndLo <= '0;
      bndCtl <= 2'h0;
    end else if (wrEn) begin
      case (paddr)
        `OHC_MASK_OFF: mask <= pwdata[`OHC_ST_W-1:0];
        `OHC_BHI_OFF: bndHi <= pwdata[`OHC_CONV_W-1:0];
        `OHC_BLO_OFF: bndLo <= pwdata[`OHC_CONV_W-1:0];
        `OHC_BCTL_OFF: bndCtl <= pwdata[1:0];
        default: bndCtl <= bndCtl;
      endcase
    end
  end

  // two edge detectors, over-current then hall
  assign edgeSel[0] = ocEdge;
  assign edgeSel[1] = hallEdge;
  assign cmpIn[0] = ocCmpIn;
  assign cmpIn[1] = hallCmpIn;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gCmp
      ohc_cmp_edge uEdge (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .edgeSel(edgeSel[g]),
        .cmpIn(cmpIn[g]),
        .evt(cmpEvt[g])
      );
    end
  endgenerate
  assign ocEvt = cmpEvt[0];
  assign hallEvt = cmpEvt[1];

  // converter boundary check on each strobed result
  // upper or lower exceed
  assign bndEvt = conv.valid &
    ((bndCtl[`OHC_BHIEN_BIT] & (conv.result > bndHi)) |
     (bndCtl[`OHC_BLOEN_BIT] & (conv.result < bndLo)));

  // event sets and write-one clears of the status register
  // gated event sources
  always_comb begin
    stSet = '0;
    stSet[`OHC_ST_OC] = ocEvt & ocIrqEn;
    stSet[`OHC_ST_HALL] = hallEvt & hallIrqEn;
    stSet[`OHC_ST_BND] = bndEvt;
    stClr = '0;
    if (wrEn && paddr == `OHC_STAT_OFF) begin
      stClr = pwdata[`OHC_ST_W-1:0];
    end
  end

  // sticky status, a set in the clearing cycle wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~stClr) | stSet;
    end
  end

  // level interrupt while an unmasked status bit is set
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat & mask);
    end
  end

  // drive trip held until the over-current status bit is cleared
  // drive shutdown on the edge after an over-current event
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      driveOff <= 1'b0;
    end else begin
      driveOff <= ocEvt | (driveOff & ~stClr[`OHC_ST_OC]);
    end
  end

  // front end settings out of one register stage
  // enables of the comparator paths
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      afeCtrl <= '0;
    end else begin
      afeCtrl.ampEn <= (gainSel != `OHC_GAIN_DIS);
      afeCtrl.ampGainSel <= gainSel;
      afeCtrl.calRefSel <= calRef;
      afeCtrl.calMode <= calMode;
      afeCtrl.offsetTrim <= trim;
      afeCtrl.ocCmpEn <= edgeOn(ocEdge);
      afeCtrl.ocDacRef <= ocDac;
      afeCtrl.hallCmpEn <= edgeOn(hallEdge);
      afeCtrl.hallDacRef <= hallDac;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // one wait state on every access
  apb_wait_one_a: assert property (
    psel && penable && !pready |=> pready)
    else $error("ready not raised after one wait state");

  // rising-edge selection reports a rise
  oc_rise_evt_a: assert property (
    ocEdge == `OHC_EDGE_RISE && $rose(ocCmpIn) |=> ocEvt)
    else $error("over-current rise missed");

  // falling-only selection ignores a rise
  oc_fall_only_a: assert property (
    ocEdge == `OHC_EDGE_FALL && $rose(ocCmpIn) |=> !ocEvt)
    else $error("rise reported under falling selection");

  // disabled hall comparator gives no events
  hall_edge_off_a: assert property (
    hallEdge == `OHC_EDGE_OFF |=> !hallEvt)
    else $error("hall event while disabled");

  // gain write reaches the amplifier two edges later
  gain_write_a: assert property (
    wrEn && paddr == `OHC_GAIN_OFF |=> ##1
    afeCtrl.ampGainSel == $past(pwdata[2:0], 2))
    else $error("gain write not applied");

  // trim write reaches the front end
  trim_write_a: assert property (
    wrEn && paddr == `OHC_CAL_OFF |=> ##1
    afeCtrl.offsetTrim == $past(pwdata[4:0], 2))
    else $error("trim write not applied");

  // reserved calibration bit reads zero
  cal_rsvd_zero_a: assert property (
    pready && !pwrite && paddr == `OHC_CAL_OFF |-> prdata[7] == 1'b0)
    else $error("reserved bit read as one");

  // over-current status only rises with its enable set
  oc_irq_gate_a: assert property (
    $rose(stat[`OHC_ST_OC]) |-> $past(ocIrqEn))
    else $error("over-current status set while disabled");

  // upper boundary exceed latches the boundary status
  bnd_high_a: assert property (
    conv.valid && bndCtl[`OHC_BHIEN_BIT] && conv.result > bndHi
    |=> stat[`OHC_ST_BND])
    else $error("boundary status missed");
  // over-current event trips the drive next edge
  drive_trip_a: assert property (
    ocEvt |=> driveOff)
    else $error("drive not tripped");
  // unmasked status raises the interrupt line
  irq_level_a: assert property (
    |(stat & mask) |=> irq)
    else $error("interrupt not raised");
  // main scenarios reached
  oc_event_c: cover property (ocEvt && ocIrqEn);
  hall_event_c: cover property (hallEvt && hallIrqEn);
  bnd_event_c: cover property (bndEvt ##1 irq);
  bad_addr_c: cover property (pready && pslverr);

endmodule
`default_nettype wire

// File: include/ohc_params.svh
// offsets, field positions, codes and reset values of the sense controller
`ifndef OHC_PARAMS_SVH
`define OHC_PARAMS_SVH

// register byte offsets on the apb bus
`define OHC_ADDR_W 8
`define OHC_GAIN_OFF 8'h00
`define OHC_OCDAC_OFF 8'h04
`define OHC_CAL_OFF 8'h08
`define OHC_HMC_OFF 8'h0c
`define OHC_HDAC_OFF 8'h10
`define OHC_STAT_OFF 8'h14
`define OHC_MASK_OFF 8'h18
`define OHC_BHI_OFF 8'h1c
`define OHC_BLO_OFF 8'h20
`define OHC_BCTL_OFF 8'h24

// field positions
`define OHC_OCEDGE_LSB 6
`define OHC_GAIN_LSB 0
`define OHC_ARS_BIT 6
`define OHC_CAL_MODE_SEL_BIT 5
`define OHC_TRIM_LSB 0
`define OHC_HEDGE_LSB 4
`define OHC_HIEN_BIT 1
`define OHC_OIEN_BIT 0
`define OHC_BLOEN_BIT 0
`define OHC_BHIEN_BIT 1

// status and mask bit positions
`define OHC_ST_OC 0
`define OHC_ST_HALL 1
`define OHC_ST_BND 2
`define OHC_ST_W 3

// widths
`define OHC_CONV_W 10
`define OHC_DAC_W 8
`define OHC_TRIM_W 5

// comparator edge codes
`define OHC_EDGE_OFF 2'h0
`define OHC_EDGE_RISE 2'h1
`define OHC_EDGE_FALL 2'h2
`define OHC_EDGE_BOTH 2'h3

// amplifier gain codes
`define OHC_GAIN_DIS 3'h0
`define OHC_GAIN_X5 3'h1
`define OHC_GAIN_X10 3'h2
`define OHC_GAIN_X20 3'h3
`define OHC_GAIN_X1 3'h7

// reset values
`define OHC_GAIN_RST `OHC_GAIN_X10
`define OHC_TRIM_RST 5'h10
`define OHC_DAC_RST 8'h00

`endif

// File: include/ohc_pkg.sv
// types shared by the sense controller files
`include "ohc_params.svh"
package ohc_pkg;

  // settings driven to the analog front end
  typedef struct packed {
    logic ampEn;
    logic [2:0] ampGainSel;
    logic calRefSel;
    logic calMode;
    logic [`OHC_TRIM_W-1:0] offsetTrim;
    logic ocCmpEn;
    logic [`OHC_DAC_W-1:0] ocDacRef;
    logic hallCmpEn;
    logic [`OHC_DAC_W-1:0] hallDacRef;
  } ohc_afe_ctrl_t;

  // one converter result with its strobe
  typedef struct packed {
    logic valid;
    logic [`OHC_CONV_W-1:0] result;
  } ohc_conv_t;

endpackage

// File: rtl/ohc_cmp_edge.sv
// edge detector for one comparator output
`timescale 1ns/1ns
`default_nettype none
module ohc_cmp_edge
  import ohc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] edgeSel,
  input wire logic cmpIn,
  output logic evt
);

  logic prev;

  // previous level, tracked even while disabled to avoid a false edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev <= 1'b0;
    end else begin
      prev <= cmpIn;
    end
  end

  // rising on code bit 0, falling on code bit 1, both on 11, none on 00
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt <= 1'b0;
    end else begin
      evt <= (edgeSel[0] & cmpIn & ~prev) | (edgeSel[1] & ~cmpIn & prev);
    end
  end

endmodule
`default_nettype wire

// File: dv/ohc_afe_model.sv
// behavioural model of the analog sense front end
`timescale 1ns/1ns
`default_nettype none
module ohc_afe_model
  import ohc_pkg::*;
(
  input wire logic core_clk,
  input wire ohc_afe_ctrl_t afeCtrl,
  output logic ocCmpIn,
  output logic hallCmpIn,
  output ohc_conv_t conv
);
  int curLevel = 0;
  int hallLevel = 0;
  int gain;
  always_comb begin
    case (afeCtrl.ampGainSel)
      3'h1: gain = 5;
      3'h2: gain = 10;
      3'h3: gain = 20;
      3'h7: gain = 1;
      default: gain = 0;
    endcase
  end
  // idle bus starts low, no strobe
  initial begin
    ocCmpIn = 1'b0;
    hallCmpIn = 1'b0;
    conv = '0;
  end
  always @(posedge core_clk) begin
    ocCmpIn <= afeCtrl.ocCmpEn && (curLevel * gain > afeCtrl.ocDacRef);
    hallCmpIn <= afeCtrl.hallCmpEn && (hallLevel > afeCtrl.hallDacRef);
  end
  // one result strobe; afterwards the bus shows the inverse, not stale data
  task automatic convert(input logic [9:0] v);
    @(posedge core_clk);
    conv <= {1'b1, v};
    @(posedge core_clk);
    conv <= {1'b0, ~v};
  endtask
endmodule
`default_nettype wire

// File: dv/ohc_ctrl_test.sv
// self-checking bench for the sense controller
`timescale 1ns/1ns
`default_nettype none
`include "ohc_params.svh"
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin \
  errTotal++; $display("unexpected %s expected %0h seen %0h", nm, e, g); \
  end end
module ohc_ctrl_test
  import ohc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ocCmpIn, hallCmpIn, driveOff, irq;
  ohc_conv_t conv;
  ohc_afe_ctrl_t afeCtrl;
  int errTotal = 0;
  int checksDone = 0;
  logic [31:0] seed = 32'h00010b13;
  logic [31:0] rdv;
  logic rde;
  int expReg [9];
  int stExp [$];
  // register table: offset, reset value, implemented bits
  logic [7:0] regAddr [9] = '{`OHC_GAIN_OFF, `OHC_OCDAC_OFF, `OHC_CAL_OFF,
    `OHC_HMC_OFF, `OHC_HDAC_OFF, `OHC_MASK_OFF, `OHC_BHI_OFF, `OHC_BLO_OFF,
    `OHC_BCTL_OFF};
  int regRst [9] = '{32'h2, 32'h0, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0};
  int regMsk [9] = '{32'hc7, 32'hff, 32'h7f, 32'h33, 32'hff, 32'h7,
    32'h3ff, 32'h3ff, 32'h3};

  ohc_ctrl ohc_ctrl_i (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ocCmpIn(ocCmpIn), .hallCmpIn(hallCmpIn), .conv(conv),
    .afeCtrl(afeCtrl), .driveOff(driveOff), .irq(irq));
  ohc_afe_model ohc_afe_model_i (.core_clk(core_clk), .afeCtrl(afeCtrl),
    .ocCmpIn(ocCmpIn), .hallCmpIn(hallCmpIn), .conv(conv));

  // 100 MHz clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction

  task automatic tallyAndFinish();
    if (errTotal == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      errTotal++;
      tallyAndFinish();
    end
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    `CHK("read data", e, rdv)
    `CHK("pslverr", 1'b0, rde)
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one comparator level change and its outcome, then clear
  task automatic edgeStep(input int ch, input int v, input int e);
    @(posedge core_clk);
    if (ch == 1) ohc_afe_model_i.hallLevel <= v;
    else ohc_afe_model_i.curLevel <= v;
    stExp.push_back(e);
    settle(6);
    rchk(`OHC_STAT_OFF, stExp.pop_front());
    `CHK("irq", e != 0, irq)
    if (ch == 0) `CHK("driveOff", e != 0, driveOff)
    apb(1'b1, `OHC_STAT_OFF, 32'h7);
  endtask

  // one conversion result and the boundary status it leaves
  task automatic bnd(input logic [9:0] v, input int e);
    stExp.push_back(e);
    ohc_afe_model_i.convert(v);
    settle(3);
    rchk(`OHC_STAT_OFF, stExp.pop_front());
    `CHK("irq", e != 0, irq)
    apb(1'b1, `OHC_STAT_OFF, 32'h7);
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    settle(2);
    `CHK("ampEn", 1'b1, afeCtrl.ampEn)
    `CHK("ampGainSel", `OHC_GAIN_RST, afeCtrl.ampGainSel)
    `CHK("offsetTrim", `OHC_TRIM_RST, afeCtrl.offsetTrim)
    for (int i = 0; i < 9; i++) begin
      rchk(regAddr[i], regRst[i]);
      seed = lfsrNext(seed);
      apb(1'b1, regAddr[i], seed);
      expReg[i] = seed & regMsk[i];
      rchk(regAddr[i], expReg[i]);
    end
    settle(2);
    `CHK("calRefSel", expReg[2][6], afeCtrl.calRefSel)
    `CHK("calMode", expReg[2][5], afeCtrl.calMode)
    `CHK("offsetTrim", expReg[2][4:0], afeCtrl.offsetTrim)
    `CHK("ocDacRef", expReg[1][7:0], afeCtrl.ocDacRef)
    `CHK("hallDacRef", expReg[4][7:0], afeCtrl.hallDacRef)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("pslverr", 1'b1, rde)
    `CHK("unmapped data", 32'h0, rdv)
    for (int g = 0; g < 8; g++) begin
      apb(1'b1, `OHC_GAIN_OFF, g);
      settle(2);
      `CHK("ampEn", g != 0, afeCtrl.ampEn)
      `CHK("ampGainSel", g[2:0], afeCtrl.ampGainSel)
    end
    // fixed references, all sources unmasked, nothing pending
    apb(1'b1, `OHC_OCDAC_OFF, 32'h80);
    apb(1'b1, `OHC_HDAC_OFF, 32'h80);
    apb(1'b1, `OHC_MASK_OFF, 32'h7);
    apb(1'b1, `OHC_BCTL_OFF, 32'h0);
    apb(1'b1, `OHC_STAT_OFF, 32'h7);
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, `OHC_GAIN_OFF, ch == 0 ? 32'h2 | (k << 6) : 32'h2);
        apb(1'b1, `OHC_HMC_OFF, ch == 1 ? 32'h3 | (k << 4) : 32'h3);
        settle(2);
        `CHK("cmpEn", k != 0, ch ? afeCtrl.hallCmpEn : afeCtrl.ocCmpEn)
        edgeStep(ch, ch ? 200 : 20, (k % 2) << ch);
        edgeStep(ch, ch ? 20 : 5, (k / 2) << ch);
      end
    end
    // interrupt requests disabled: no status, drive still cut
    apb(1'b1, `OHC_GAIN_OFF, 32'h42);
    apb(1'b1, `OHC_HMC_OFF, 32'h0);
    @(posedge core_clk);
    ohc_afe_model_i.curLevel <= 20;
    settle(6);
    `CHK("driveOff", 1'b1, driveOff)
    rchk(`OHC_STAT_OFF, 0);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, `OHC_STAT_OFF, 32'h1);
    settle(2);
    `CHK("driveOff", 1'b0, driveOff)
    // boundary checks above the upper and below the lower limit
    apb(1'b1, `OHC_BHI_OFF, 32'h200);
    apb(1'b1, `OHC_BLO_OFF, 32'h100);
    apb(1'b1, `OHC_BCTL_OFF, 32'h2);
    bnd(10'h300, 4);
    bnd(10'h050, 0);
    apb(1'b1, `OHC_BCTL_OFF, 32'h1);
    bnd(10'h050, 4);
    bnd(10'h300, 0);
    seed = lfsrNext(seed);
    apb(1'b1, `OHC_BCTL_OFF, 32'h3);
    bnd(10'h101 + seed[6:0], 0);
    apb(1'b1, `OHC_MASK_OFF, 32'h3);
    ohc_afe_model_i.convert(10'h3ff);
    settle(3);
    `CHK("masked irq", 1'b0, irq)
    rchk(`OHC_STAT_OFF, 4);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
